// >>> csr_dev.sv
// charger end: bus slave with the charge setting words
// assumes a master on csr_if; scl and sda are foreign to clk_sys_i
`timescale 1ns/1ps
`default_nettype none
`include "csr_cfg.svh"
module csr_dev #(
  parameter logic [15:0] MAKER_CODE = 16'h5A01,  // arbitrary value
  parameter logic [15:0] PART_CODE  = 16'h5A02   // arbitrary value
) (
  input  wire logic  clk_sys_i,
  input  wire logic  nrst_i,
  input  wire logic  ce_i,
  csr_if.dev         bus,
  input  wire logic  pwm_hi_i,
  output logic [15:0] chg_curr_o,
  output logic [15:0] chg_volt_o,
  output logic [15:0] in_lim_o,
  output logic        charge_en_o,
  output logic        hs_fet_en_o,
  output logic        ls_fet_en_o
);
  // =============================================================
  // write checks
  function automatic logic [15:0] volt_chk(input logic [15:0] d);
    logic [15:0] m;
    m = d & `CSR_VOLT_MASK;
    if (m < `CSR_VOLT_MIN || m > `CSR_VOLT_MAX) begin
      volt_chk = 16'h0000;
    end else begin
      volt_chk = m;
    end
  endfunction

  function automatic logic [15:0] curr_chk(input logic [15:0] d);
    logic [15:0] m;
    m = d & `CSR_CURR_MASK;
    if ((d != 16'h0000 && m == 16'h0000) || (d & `CSR_CURR_OVER) != 16'h0000) begin
      curr_chk = 16'h0000;
    end else begin
      curr_chk = m;
    end
  endfunction

  function automatic logic [15:0] ilim_chk(input logic [15:0] d);
    logic [15:0] m;
    m = d & `CSR_CURR_MASK;
    // a written value up to the lowest step also cuts charging
    if (d != 16'h0000 && m <= `CSR_ILIM_LOW) begin
      ilim_chk = 16'h0000;
    end else begin
      ilim_chk = m;
    end
  endfunction

  // =============================================================
  // state
  csr_pkg::csr_dev_s r;
  csr_pkg::csr_dev_s n;
  logic rise;
  logic fall;
  logic start;
  logic stop;

  always_comb begin
    n     = r;
    rise  = 1'b0;
    fall  = 1'b0;
    start = 1'b0;
    stop  = 1'b0;
    if (ce_i) begin
      // three-stage sync, a level counts once stages two and three agree
      n.scl_s = {r.scl_s[1:0], bus.scl};
      n.sda_s = {r.sda_s[1:0], bus.sda};
      if (r.scl_s[2] == r.scl_s[1]) begin
        n.scl_f = r.scl_s[2];
      end
      if (r.sda_s[2] == r.sda_s[1]) begin
        n.sda_f = r.sda_s[2];
      end
      rise  = n.scl_f & ~r.scl_f;
      fall  = ~n.scl_f & r.scl_f;
      start = r.scl_f & n.scl_f & r.sda_f & ~n.sda_f;
      stop  = r.scl_f & n.scl_f & ~r.sda_f & n.sda_f;
      if (stop) begin
        n.st      = csr_pkg::D_IDLE;
        n.sda_low = 1'b0;
      end else if (start) begin
        // repeated start lands here too and reopens the address byte
        n.st      = csr_pkg::D_RX;
        n.idx     = 3'h0;
        n.bitc    = 3'h0;
        n.sda_low = 1'b0;
      end else if (rise) begin
        unique case (r.st)
          csr_pkg::D_RX: begin
            n.sh   = {r.sh[6:0], n.sda_f};
            n.bitc = r.bitc + 3'h1;
            if (r.bitc == 3'h7) begin
              n.st = csr_pkg::D_ACKP;
              unique case (r.idx)
                3'h0: begin
                  if (n.sh[7:1] != `CSR_SLAVE_ADDR) begin
                    n.st = csr_pkg::D_IDLE;
                  end else begin
                    n.rw = n.sh[0];
                  end
                end
                3'h1: n.cmd = n.sh;
                3'h2: n.lo = n.sh;
                3'h3: begin
                  // commit only once the high byte is whole
                  unique case (r.cmd)
                    `CSR_CMD_CURR: n.curr = curr_chk({n.sh, r.lo});
                    `CSR_CMD_VOLT: n.volt = volt_chk({n.sh, r.lo});
                    `CSR_CMD_ILIM: n.ilim = ilim_chk({n.sh, r.lo});
                    default: ;
                  endcase
                end
                default: n.st = csr_pkg::D_IDLE;
              endcase
            end
          end
          csr_pkg::D_TX: begin
            n.bitc = r.bitc + 3'h1;
            if (r.bitc == 3'h7) begin
              n.st = csr_pkg::D_MREL;
            end
          end
          csr_pkg::D_MACK: begin
            if (!n.sda_f && !r.hi_sent) begin
              n.hi_sent = 1'b1;
              n.sh      = r.txw[15:8];
              n.st      = csr_pkg::D_TXL;
            end else begin
              n.st = csr_pkg::D_IDLE;
            end
          end
          default: ;
        endcase
      end else if (fall) begin
        // all sda changes happen right after scl falls
        unique case (r.st)
          csr_pkg::D_ACKP: begin
            n.sda_low = 1'b1;
            n.st      = csr_pkg::D_ACK;
          end
          csr_pkg::D_ACK: begin
            n.sda_low = 1'b0;
            n.bitc    = 3'h0;
            n.idx     = r.idx + 3'h1;
            n.st      = csr_pkg::D_RX;
            if (r.idx == 3'h0 && r.rw) begin
              unique case (r.cmd)
                `CSR_CMD_CURR:  n.txw = r.curr;
                `CSR_CMD_VOLT:  n.txw = r.volt;
                `CSR_CMD_ILIM:  n.txw = r.ilim;
                `CSR_CMD_MAKER: n.txw = MAKER_CODE;
                `CSR_CMD_PART:  n.txw = PART_CODE;
                default:        n.txw = 16'h0000;
              endcase
              n.sh      = n.txw[7:0];
              n.hi_sent = 1'b0;
              n.sda_low = ~n.txw[7];
              n.st      = csr_pkg::D_TX;
            end
          end
          csr_pkg::D_TX: begin
            n.sh      = {r.sh[6:0], 1'b0};
            n.sda_low = ~n.sh[7];
          end
          csr_pkg::D_MREL: begin
            n.sda_low = 1'b0;
            n.st      = csr_pkg::D_MACK;
          end
          csr_pkg::D_TXL: begin
            n.bitc    = 3'h0;
            n.sda_low = ~r.sh[7];
            n.st      = csr_pkg::D_TX;
          end
          default: ;
        endcase
      end
    end
  end

  always_ff @(posedge clk_sys_i or negedge nrst_i) begin
    if (!nrst_i) begin
      r       <= '0;
      r.scl_s <= 3'h7;
      r.sda_s <= 3'h7;
      r.scl_f <= 1'b1;
      r.sda_f <= 1'b1;
      r.curr  <= `CSR_CURR_RST;
      r.volt  <= `CSR_VOLT_RST;
      r.ilim  <= `CSR_ILIM_RST;
    end else begin
      r <= n;
    end
  end

  // =============================================================
  // outputs
  // the slave never drives scl and only pulls sda low
  assign bus.dev_sda_o    = 1'b0;
  assign bus.dev_sda_oe_n = ~r.sda_low;
  assign chg_curr_o       = r.curr;
  assign chg_volt_o       = r.volt;
  assign in_lim_o         = r.ilim;
  // a zero setting means not written or cleared, so volt, curr and ilim all gate charging
  assign charge_en_o = (r.volt != 16'h0000) && (r.curr != 16'h0000)
                       && (r.ilim != 16'h0000);
  assign hs_fet_en_o = charge_en_o & pwm_hi_i;
  assign ls_fet_en_o = charge_en_o & ~pwm_hi_i;
endmodule  // csr_dev
`default_nettype wire

// >>> csr_cfg.svh
// constants of the charger setting registers and their serial bus
// assumes a 50 MHz system clock; included by both ends
`ifndef CSR_CFG_SVH
`define CSR_CFG_SVH
`define CSR_SLAVE_ADDR  7'h09
`define CSR_CMD_CURR    8'h14
`define CSR_CMD_VOLT    8'h15
`define CSR_CMD_ILIM    8'h3F
`define CSR_CMD_MAKER   8'hFE
`define CSR_CMD_PART    8'hFF
`define CSR_CURR_RST    16'h0000
`define CSR_VOLT_RST    16'h0000
`define CSR_ILIM_RST    16'h0080
`define CSR_VOLT_MASK   16'h7FF0
`define CSR_VOLT_MIN    16'h0400
`define CSR_VOLT_MAX    16'h4B00
`define CSR_CURR_MASK   16'h1F80
`define CSR_CURR_OVER   16'hE000
`define CSR_ILIM_LOW    16'h0080
`define CSR_CLK_NS      20
`define CSR_SCL_NS      10000
`define CSR_QTR_CYC     ((`CSR_SCL_NS / 4) / `CSR_CLK_NS)
`endif

// >>> csr_pkg.sv
// types shared by both ends of the charger setting link
// assumes csr_cfg.svh for numeric constants
`default_nettype none
package csr_pkg;
  typedef enum logic [2:0] {
    D_IDLE, D_RX, D_ACKP, D_ACK, D_TX, D_MREL, D_MACK, D_TXL
  } csr_dst_e;
  typedef enum logic [1:0] {K_START, K_TX, K_RX, K_STOP} csr_kind_e;
  typedef enum logic {H_IDLE, H_RUN} csr_hst_e;

  typedef struct packed {
    logic [2:0]  scl_s;
    logic [2:0]  sda_s;
    logic        scl_f;
    logic        sda_f;
    csr_dst_e    st;
    logic        wait_stop;
    logic [2:0]  bitc;
    logic [7:0]  sh;
    logic [2:0]  idx;
    logic        rw;
    logic        hi_sent;
    logic [7:0]  cmd;
    logic [7:0]  lo;
    logic [15:0] txw;
    logic        sda_low;
    logic [15:0] curr;
    logic [15:0] volt;
    logic [15:0] ilim;
  } csr_dev_s;

  typedef struct packed {
    csr_hst_e    st;
    logic [2:0]  sda_s;
    logic        sda_f;
    logic [15:0] qc;
    logic [1:0]  q;
    logic [2:0]  step;
    logic [3:0]  slot;
    logic        wr;
    logic [7:0]  cmd;
    logic [15:0] wd;
    logic [7:0]  sh;
    logic [15:0] rd;
    logic        scl_low;
    logic        sda_low;
    logic        nack;
    logic        done;
  } csr_host_s;
endpackage
`default_nettype wire

// >>> csr_if.sv
// open-drain two-wire link between the host end and the charger end
// assumes each party drives low only, with active-low output enables
`timescale 1ns/1ps
`default_nettype none
interface csr_if;
  logic scl;
  logic sda;
  logic host_scl_o;
  logic host_scl_oe_n;
  logic host_sda_o;
  logic host_sda_oe_n;
  logic dev_sda_o;
  logic dev_sda_oe_n;

  // wired-and of all drivers, pull-ups give the idle high
  assign scl = host_scl_oe_n | host_scl_o;
  assign sda = (host_sda_oe_n | host_sda_o) & (dev_sda_oe_n | dev_sda_o);

  modport dev  (input scl, input sda, output dev_sda_o, output dev_sda_oe_n);
  modport host (input scl, input sda, output host_scl_o, output host_scl_oe_n,
                output host_sda_o, output host_sda_oe_n);
endinterface
`default_nettype wire

// >>> csr_host.sv
// host end: bus master issuing word reads and writes to the charger
// assumes csr_if; scl is made here by dividing clk_sys_i
`timescale 1ns/1ps
`default_nettype none
`include "csr_cfg.svh"
module csr_host #(
  parameter int unsigned QTR_CYC = `CSR_QTR_CYC
) (
  input  wire logic        clk_sys_i,
  input  wire logic        nrst_i,
  input  wire logic        ce_i,
  csr_if.host              bus,
  input  wire logic        req_i,
  input  wire logic        wr_i,
  input  wire logic [7:0]  cmd_i,
  input  wire logic [15:0] wdata_i,
  output logic             busy_o,
  output logic             done_o,
  output logic             nack_o,
  output logic [15:0]      rdata_o
);
  // =============================================================
  // transaction script
  function automatic csr_pkg::csr_kind_e step_kind(input logic wr, input logic [2:0] s);
    if (s == 3'h0 || (!wr && s == 3'h3)) begin
      step_kind = csr_pkg::K_START;
    end else if ((wr && s == 3'h5) || s == 3'h7) begin
      step_kind = csr_pkg::K_STOP;
    end else if (!wr && s >= 3'h5) begin
      step_kind = csr_pkg::K_RX;
    end else begin
      step_kind = csr_pkg::K_TX;
    end
  endfunction

  function automatic logic [7:0] tx_byte(input csr_pkg::csr_host_s h);
    unique case (h.step)
      3'h1:    tx_byte = {`CSR_SLAVE_ADDR, 1'b0};
      3'h2:    tx_byte = h.cmd;
      3'h3:    tx_byte = h.wd[7:0];
      3'h4:    tx_byte = h.wr ? h.wd[15:8] : {`CSR_SLAVE_ADDR, 1'b1};
      default: tx_byte = 8'h00;
    endcase
  endfunction

  // =============================================================
  // state
  csr_pkg::csr_host_s r;
  csr_pkg::csr_host_s n;
  csr_pkg::csr_kind_e kind;
  logic [7:0]         b;

  always_comb begin
    n      = r;
    kind   = step_kind(r.wr, r.step);
    b      = tx_byte(r);
    if (ce_i) begin
      // the pulse is frozen with the rest while the enable is low
      n.done  = 1'b0;
      n.sda_s = {r.sda_s[1:0], bus.sda};
      if (r.sda_s[2] == r.sda_s[1]) begin
        n.sda_f = r.sda_s[2];
      end
      unique case (r.st)
        csr_pkg::H_IDLE: begin
          if (req_i) begin
            n.st   = csr_pkg::H_RUN;
            n.wr   = wr_i;
            n.cmd  = cmd_i;
            n.wd   = wdata_i;
            n.step = 3'h0;
            n.slot = 4'h0;
            n.q    = 2'h0;
            n.qc   = 16'h0000;
            n.nack = 1'b0;
          end
        end
        csr_pkg::H_RUN: begin
          if (r.qc == 16'(QTR_CYC - 1)) begin
            n.qc = 16'h0000;
            n.q  = r.q + 2'h1;
            unique case (kind)
              csr_pkg::K_START: begin
                unique case (r.q)
                  2'h0: n.sda_low = 1'b0;
                  2'h1: n.scl_low = 1'b0;
                  2'h2: n.sda_low = 1'b1;
                  2'h3: begin
                    n.scl_low = 1'b1;
                    n.step    = r.step + 3'h1;
                  end
                endcase
              end
              csr_pkg::K_STOP: begin
                unique case (r.q)
                  2'h0: n.sda_low = 1'b1;
                  2'h1: n.scl_low = 1'b0;
                  2'h2: n.sda_low = 1'b0;
                  2'h3: begin
                    n.st   = csr_pkg::H_IDLE;
                    n.done = 1'b1;
                  end
                endcase
              end
              default: begin
                unique case (r.q)
                  2'h0: begin
                    // data set while scl is low, msb first
                    if (r.slot == 4'h8) begin
                      n.sda_low = (kind == csr_pkg::K_RX) && (r.step == 3'h5);
                    end else begin
                      n.sda_low = (kind == csr_pkg::K_TX) && !b[3'(4'h7 - r.slot)];
                    end
                  end
                  2'h1: n.scl_low = 1'b0;
                  2'h2: begin
                    if (r.slot != 4'h8) begin
                      n.sh = {r.sh[6:0], r.sda_f};
                    end else if (kind == csr_pkg::K_TX) begin
                      n.nack = r.nack | r.sda_f;
                    end
                  end
                  2'h3: begin
                    n.scl_low = 1'b1;
                    n.slot    = r.slot + 4'h1;
                    if (r.slot == 4'h8) begin
                      n.slot = 4'h0;
                      n.step = r.step + 3'h1;
                      if (kind == csr_pkg::K_RX && r.step == 3'h5) begin
                        n.rd[7:0] = r.sh;
                      end
                      if (kind == csr_pkg::K_RX && r.step == 3'h6) begin
                        n.rd[15:8] = r.sh;
                      end
                      // a refused byte ends the frame early
                      if (r.nack) begin
                        n.step = r.wr ? 3'h5 : 3'h7;
                      end
                    end
                  end
                endcase
              end
            endcase
          end else begin
            n.qc = r.qc + 16'h0001;
          end
        end
      endcase
    end
  end

  always_ff @(posedge clk_sys_i or negedge nrst_i) begin
    if (!nrst_i) begin
      r       <= '0;
      r.sda_s <= 3'h7;
      r.sda_f <= 1'b1;
    end else begin
      r <= n;
    end
  end

  // =============================================================
  // outputs
  assign bus.host_scl_o    = 1'b0;
  assign bus.host_scl_oe_n = ~r.scl_low;
  assign bus.host_sda_o    = 1'b0;
  assign bus.host_sda_oe_n = ~r.sda_low;
  assign busy_o            = (r.st == csr_pkg::H_RUN);
  assign done_o            = r.done;
  assign nack_o            = r.nack;
  assign rdata_o           = r.rd;
endmodule  // csr_host
`default_nettype wire

// >>> csr_link_asserts.sv
// checker for the two-wire link between the host end and the charger end
// assumes plain copies of the csr_if wires and a host quarter of 8 clocks
`timescale 1ns/1ps
`default_nettype none
module csr_link_asserts (
  input wire logic clk_sys_i,
  input wire logic nrst_i,
  input wire logic scl,
  input wire logic sda,
  input wire logic host_scl_o,
  input wire logic host_scl_oe_n,
  input wire logic host_sda_o,
  input wire logic host_sda_oe_n,
  input wire logic dev_sda_o,
  input wire logic dev_sda_oe_n
);
  // ==========================================================
  // frame tracking on the resolved wires
  logic       scl_q;
  logic       sda_q;
  logic       in_frame;
  logic [5:0] rise_cnt;
  wire        start_c = scl_q & scl & sda_q & ~sda;
  wire        stop_c  = scl_q & scl & ~sda_q & sda;

  always_ff @(posedge clk_sys_i or negedge nrst_i) begin
    if (!nrst_i) begin
      scl_q    <= 1'b1;
      sda_q    <= 1'b1;
      in_frame <= 1'b0;
      rise_cnt <= 6'h00;
    end else begin
      scl_q <= scl;
      sda_q <= sda;
      if (start_c) begin
        in_frame <= 1'b1;
        rise_cnt <= 6'h00;
      end else if (stop_c) begin
        in_frame <= 1'b0;
        rise_cnt <= 6'h00;
      end else if (~scl_q & scl) begin
        rise_cnt <= rise_cnt + 6'h01;
      end
    end
  end

  // ==========================================================
  // properties
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (!nrst_i);

  sequence s_start_hold;
    scl [*6] ##[1:3] !scl;
  endsequence
  sequence s_held_to_rise;
    !dev_sda_oe_n throughout (##[1:20] scl);
  endsequence

  property p_idle_quiet;
    !in_frame |-> dev_sda_oe_n;
  endproperty
  property p_dev_hold;
    scl && $past(scl) |-> $stable(dev_sda_oe_n);
  endproperty
  property p_dev_release;
    $rose(dev_sda_oe_n) |-> !scl;
  endproperty
  property p_dev_ack;
    $fell(dev_sda_oe_n) |-> !scl ##0 s_held_to_rise;
  endproperty
  property p_host_quiet;
    $changed(host_sda_oe_n) && scl |-> $past(scl, 4);
  endproperty
  property p_start_clock;
    $fell(host_sda_oe_n) && scl |=> s_start_hold;
  endproperty
  property p_stop_free;
    $rose(host_sda_oe_n) && scl |=> host_scl_oe_n [*8];
  endproperty
  // a repeated start follows address and command: 18 clocks plus its own rise
  property p_nine_clocks;
    start_c |-> (rise_cnt == 6'h00) || (rise_cnt == 6'h13);
  endproperty
  property p_stop_count;
    stop_c |-> (rise_cnt % 6'h09) == 6'h01;
  endproperty

  a_idle_quiet: assert property (p_idle_quiet) else $error("device drove sda outside a frame");
  a_dev_hold: assert property (p_dev_hold) else $error("device moved sda while scl high");
  a_dev_release: assert property (p_dev_release) else $error("device released sda with scl high");
  a_dev_ack: assert property (p_dev_ack) else $error("device low bit not held to scl rise");
  a_host_quiet: assert property (p_host_quiet) else $error("host moved sda early in scl high");
  a_start_clock: assert property (p_start_clock) else $error("start not followed by scl low");
  a_stop_free: assert property (p_stop_free) else $error("scl pulled after stop");
  a_nine_clocks: assert property (p_nine_clocks) else $error("start after partial byte");
  a_stop_count: assert property (p_stop_count) else $error("stop after partial byte");
endmodule // csr_link_asserts
`default_nettype wire

// >>> charger_smbus_setting_regs_test.sv
// self-checking bench: host end against charger end, plus a hand-driven bus
// assumes csr_if, csr_dev, csr_host and csr_link_asserts compiled before
`timescale 1ns/1ps
`default_nettype none
module charger_smbus_setting_regs_test;
  localparam logic [15:0] MAKER = 16'h3C11;  // arbitrary value
  localparam logic [15:0] PART  = 16'h3C22;  // arbitrary value
  logic        clk_sys_i;
  logic        nrst_i;
  logic        req;
  logic        wr;
  logic        pwm_hi;
  logic [7:0]  cmd;
  logic [15:0] wdata;
  logic [15:0] rdata;
  logic [15:0] curr;
  logic [15:0] volt;
  logic [15:0] ilim;
  logic [15:0] volt2;
  logic        busy;
  logic        done;
  logic        nack;
  logic        chg_en;
  logic        hs;
  logic        ls;
  logic        bb_scl_n;
  logic        bb_sda_n;
  logic        scl_q;
  logic        sda_q;
  logic [8:0]  mon_sh;
  logic [7:0]  br;
  logic        ba;
  logic        ce2;
  int          mon_n = 9;
  int          n_mismatch;
  int          samples_checked;

  csr_if ifc();
  csr_if ifc2();
  // second bus is bit-banged so the bench can break the host's rules
  assign ifc2.host_scl_o    = 1'b0;
  assign ifc2.host_sda_o    = 1'b0;
  assign ifc2.host_scl_oe_n = bb_scl_n;
  assign ifc2.host_sda_oe_n = bb_sda_n;

  csr_dev #(.MAKER_CODE(MAKER), .PART_CODE(PART)) csr_dev_inst (.clk_sys_i(clk_sys_i),
    .nrst_i(nrst_i), .ce_i(1'b1), .bus(ifc.dev), .pwm_hi_i(pwm_hi), .chg_curr_o(curr),
    .chg_volt_o(volt), .in_lim_o(ilim), .charge_en_o(chg_en), .hs_fet_en_o(hs), .ls_fet_en_o(ls));
  csr_dev #(.MAKER_CODE(MAKER), .PART_CODE(PART)) csr_dev_inst2 (.clk_sys_i(clk_sys_i),
    .nrst_i(nrst_i), .ce_i(ce2), .bus(ifc2.dev), .pwm_hi_i(pwm_hi), .chg_curr_o(),
    .chg_volt_o(volt2), .in_lim_o(), .charge_en_o(), .hs_fet_en_o(), .ls_fet_en_o());
  csr_host #(.QTR_CYC(8)) csr_host_inst (.clk_sys_i(clk_sys_i), .nrst_i(nrst_i), .ce_i(1'b1),
    .bus(ifc.host), .req_i(req), .wr_i(wr), .cmd_i(cmd), .wdata_i(wdata), .busy_o(busy),
    .done_o(done), .nack_o(nack), .rdata_o(rdata));
  csr_link_asserts csr_link_asserts_inst (.clk_sys_i(clk_sys_i), .nrst_i(nrst_i),
    .scl(ifc.scl), .sda(ifc.sda), .host_scl_o(ifc.host_scl_o),
    .host_scl_oe_n(ifc.host_scl_oe_n), .host_sda_o(ifc.host_sda_o),
    .host_sda_oe_n(ifc.host_sda_oe_n), .dev_sda_o(ifc.dev_sda_o),
    .dev_sda_oe_n(ifc.dev_sda_oe_n));

  // ==========================================================
  // clock and wire monitor
  initial begin
    clk_sys_i = 1'b0;
    forever #10 clk_sys_i = ~clk_sys_i;
  end

  // negedge sampling keeps clear of the design's register updates
  always @(negedge clk_sys_i) begin
    scl_q <= ifc.scl;
    sda_q <= ifc.sda;
    if (scl_q && ifc.scl && sda_q && !ifc.sda) begin
      mon_n <= 0;
    end else if (!scl_q && ifc.scl && mon_n < 9) begin
      mon_n  <= mon_n + 1;
      mon_sh <= {mon_sh[7:0], ifc.sda};
    end
  end

  // ==========================================================
  // tasks
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    samples_checked++;
    if (got !== exp) begin
      n_mismatch++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic print_verdict;
    $display("checks %0d mismatches %0d", samples_checked, n_mismatch);
    if (n_mismatch == 0 && samples_checked > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask

  task automatic xfer(input logic w, input logic [7:0] c, input logic [15:0] d);
    @(posedge clk_sys_i);
    req   <= 1'b1;
    wr    <= w;
    cmd   <= c;
    wdata <= d;
    @(posedge clk_sys_i);
    req <= 1'b0;
    @(negedge clk_sys_i);
    chk(16'(busy), 16'h0001);
    for (int i = 0; i < 3000 && done !== 1'b1; i++) @(negedge clk_sys_i);
    if (done !== 1'b1) begin
      n_mismatch++;
      $display("CHECK FAILED at %0t: frame did not finish", $time);
    end
    chk(16'(busy), 16'h0000);
    chk(16'(nack), 16'h0000);
    chk(16'(mon_sh), {7'h00, 7'h09, !w, 1'b0});
  endtask

  task automatic rd(input logic [7:0] c, input logic [15:0] e);
    xfer(1'b0, c, 16'h0000);
    chk(rdata, e);
  endtask

  task automatic wrd(input logic [7:0] c, input logic [15:0] d, input logic [15:0] e);
    xfer(1'b1, c, d);
    rd(c, e);
  endtask

  task automatic bq;
    repeat (8) @(posedge clk_sys_i);
  endtask

  task automatic bb_bit(input logic b, output logic s);
    bb_sda_n <= b;
    bq();
    bb_scl_n <= 1'b1;
    bq();
    // sampled off the edge so a launch at this edge cannot race
    @(negedge clk_sys_i);
    s = ifc2.sda;
    bq();
    bb_scl_n <= 1'b0;
    bq();
  endtask

  task automatic bb_start;
    bb_sda_n <= 1'b1;
    bq();
    bb_scl_n <= 1'b1;
    bq();
    bb_sda_n <= 1'b0;
    bq();
    bb_scl_n <= 1'b0;
    bq();
  endtask

  task automatic bb_stop;
    bb_sda_n <= 1'b0;
    bq();
    bb_scl_n <= 1'b1;
    bq();
    bb_sda_n <= 1'b1;
    bq();
  endtask

  task automatic bb_byte(input logic [7:0] v, input logic m9, output logic [7:0] r,
                         output logic a);
    for (int i = 7; i >= 0; i--) bb_bit(v[i], r[i]);
    bb_bit(m9, a);
  endtask

  task automatic bb_tx(input logic [7:0] v, input logic exp_ack);
    logic [7:0] r;
    logic       a;
    bb_byte(v, 1'b1, r, a);
    chk(16'(a), 16'(exp_ack));
  endtask

  // ==========================================================
  // sequence of tests
  initial begin
    // the planned run takes about 56000 cycles
    repeat (90000) @(posedge clk_sys_i);
    n_mismatch++;
    $display("CHECK FAILED at %0t: watchdog expired", $time);
    print_verdict();
  end

  initial begin
    nrst_i   = 1'b0;
    req      = 1'b0;
    wr       = 1'b0;
    cmd      = 8'h00;
    wdata    = 16'h0000;
    pwm_hi   = 1'b1;
    bb_scl_n = 1'b1;
    bb_sda_n = 1'b1;
    ce2      = 1'b1;
    repeat (6) @(posedge clk_sys_i);
    chk(16'(hs), 16'h0000);
    chk(16'(ls), 16'h0000);
    nrst_i <= 1'b1;
    rd(8'h14, 16'h0000);
    rd(8'h15, 16'h0000);
    rd(8'h3F, 16'h0080);
    rd(8'hFE, MAKER);
    rd(8'hFF, PART);
    wrd(8'h15, 16'h3013, 16'h3010);
    chk(16'(chg_en), 16'h0000);
    wrd(8'h14, 16'h0FFF, 16'h0F80);
    chk(16'(hs), 16'h0001);
    @(posedge clk_sys_i);
    pwm_hi <= 1'b0;
    @(negedge clk_sys_i);
    chk(16'(ls), 16'h0001);
    wrd(8'h15, 16'h03F0, 16'h0000);
    chk(16'(chg_en), 16'h0000);
    wrd(8'h15, 16'h0400, 16'h0400);
    wrd(8'h15, 16'h4B00, 16'h4B00);
    wrd(8'h15, 16'h4B10, 16'h0000);
    wrd(8'h15, 16'h8400, 16'h0400);
    wrd(8'h15, 16'h4000, 16'h4000);
    wrd(8'h14, 16'h0040, 16'h0000);
    wrd(8'h14, 16'h2F80, 16'h0000);
    wrd(8'h14, 16'h1F80, 16'h1F80);
    wrd(8'h3F, 16'h0080, 16'h0000);
    wrd(8'h3F, 16'h0040, 16'h0000);
    wrd(8'h3F, 16'h1F80, 16'h1F80);
    xfer(1'b1, 8'hFE, 16'h1234);
    xfer(1'b1, 8'h20, 16'h5555);
    rd(8'hFE, MAKER);
    rd(8'h20, 16'h0000);
    chk(curr, 16'h1F80);
    chk(volt, 16'h4000);
    @(posedge clk_sys_i);
    nrst_i <= 1'b0;
    repeat (3) @(posedge clk_sys_i);
    nrst_i <= 1'b1;
    @(negedge clk_sys_i);
    chk(curr, 16'h0000);
    chk(volt, 16'h0000);
    chk(ilim, 16'h0080);
    bb_start();
    bb_tx(8'h14, 1'b1);
    bb_stop();
    bb_start();
    bb_tx(8'h12, 1'b0);
    bb_tx(8'h15, 1'b0);
    bb_tx(8'h00, 1'b0);
    bb_tx(8'h10, 1'b0);
    bb_stop();
    chk(volt2, 16'h1000);
    bb_start();
    bb_tx(8'h12, 1'b0);
    bb_tx(8'h15, 1'b0);
    bb_tx(8'h20, 1'b0);
    bb_stop();
    chk(volt2, 16'h1000);
    // a frozen charger end must not answer its address
    ce2 <= 1'b0;
    bb_start();
    bb_tx(8'h12, 1'b1);
    bb_stop();
    ce2 <= 1'b1;
    bb_start();
    bb_tx(8'h12, 1'b0);
    bb_tx(8'h15, 1'b0);
    bb_start();
    bb_tx(8'h13, 1'b0);
    bb_byte(8'hFF, 1'b0, br, ba);
    chk(16'(br), 16'h0000);
    bb_byte(8'hFF, 1'b1, br, ba);
    chk(16'(br), 16'h0010);
    bb_stop();
    print_verdict();
  end
endmodule // charger_smbus_setting_regs_test
`default_nettype wire
